/* File: bhw_cfg.svh */
// constants for the bridge header bus and io window register slice
`ifndef BHW_CFG_SVH
`define BHW_CFG_SVH

// register indices; byte address is four times the index
`define BHW_IDX_PRI_LAT      6'h0d
`define BHW_IDX_HDR_CODE     6'h0e
`define BHW_IDX_SELF_TEST    6'h0f
`define BHW_IDX_BASE_ZERO    6'h10
`define BHW_IDX_BASE_ONE     6'h14
`define BHW_IDX_UPSTREAM     6'h18
`define BHW_IDX_DOWNSTREAM   6'h19
`define BHW_IDX_HIGHEST      6'h1a
`define BHW_IDX_SEC_LAT      6'h1b
`define BHW_IDX_IO_LOW       6'h1c
`define BHW_IDX_IO_HIGH      6'h1d
`define BHW_IDX_LOCK_CTRL    6'h30

// fixed read values
`define BHW_VAL_LAT          8'h00
`define BHW_VAL_HDR_CODE     8'h01
`define BHW_VAL_SELF_TEST    8'h00
`define BHW_VAL_BASE_WIN     32'h0000_0000

// reset values
`define BHW_RST_SEGMENT      8'h00
`define BHW_RST_WIDTH_FLAG   1'h1
`define BHW_RST_IO_LOW       4'hf
`define BHW_RST_IO_HIGH      4'h0
`define BHW_RST_LOCK         1'h0

// field positions inside io_window_low and io_window_high
`define BHW_POS_FLAG         0
`define BHW_POS_ADDR_LSB     4
`define BHW_POS_ADDR_MSB     7

// low twelve address bits of the window ends
`define BHW_IO_LOW_FILL      12'h000
`define BHW_IO_HIGH_FILL     12'hfff

`endif

/* File: bhw_pkg.sv */
// types shared by the bridge header register slice
`default_nettype none

package bhw_pkg;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        we;
		logic        re;
	} bhw_bus_req_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
	} bhw_io_req_t;

	typedef struct packed {
		logic valid;
		logic hit;
	} bhw_io_res_t;

	typedef struct packed {
		logic [7:0]  upstream;
		logic [7:0]  downstream;
		logic [7:0]  highest;
		logic        width_flag;
		logic [3:0]  io_low;
		logic [3:0]  io_high;
		logic        lock;
		logic [31:0] rd_data;
	} bhw_regs_st_t;

endpackage : bhw_pkg

`default_nettype wire

/* File: bhw_rd_mux.sv */
// read data selection for the bridge header register slice
`default_nettype none
`include "bhw_cfg.svh"

module bhw_rd_mux (
	input  wire logic [5:0]  idx,
	input  wire logic [7:0]  upstream,
	input  wire logic [7:0]  downstream,
	input  wire logic [7:0]  highest,
	input  wire logic        width_flag,
	input  wire logic [3:0]  io_low,
	input  wire logic [3:0]  io_high,
	input  wire logic        lock,
	output var  logic [31:0] word
);

	always_comb begin
		word = 32'h0000_0000;
		case (idx)
			`BHW_IDX_PRI_LAT:    word = {24'h00_0000, `BHW_VAL_LAT};
			`BHW_IDX_SEC_LAT:    word = {24'h00_0000, `BHW_VAL_LAT};
			`BHW_IDX_HDR_CODE:   word = {24'h00_0000, `BHW_VAL_HDR_CODE};
			`BHW_IDX_SELF_TEST:  word = {24'h00_0000, `BHW_VAL_SELF_TEST};
			`BHW_IDX_BASE_ZERO:  word = `BHW_VAL_BASE_WIN;
			`BHW_IDX_BASE_ONE:   word = `BHW_VAL_BASE_WIN;
			`BHW_IDX_UPSTREAM:   word = {24'h00_0000, upstream};
			`BHW_IDX_DOWNSTREAM: word = {24'h00_0000, downstream};
			`BHW_IDX_HIGHEST:    word = {24'h00_0000, highest};
			// reserved 3:1 always zero
			`BHW_IDX_IO_LOW:     word = {24'h00_0000, io_low, 3'h0, width_flag};
			`BHW_IDX_IO_HIGH:    word = {24'h00_0000, io_high, 3'h0, width_flag};
			`BHW_IDX_LOCK_CTRL:  word = {31'h0000_0000, lock};
			default:             word = 32'h0000_0000;
		endcase
	end

endmodule : bhw_rd_mux

`default_nettype wire

/* File: bhw_io_match.sv */
// io forwarding window compare, one registered answer per request
`default_nettype none
`include "bhw_cfg.svh"

module bhw_io_match (
	input  wire logic                 clk,
	input  wire logic                 arst_n,
	input  wire logic [3:0]           io_low,
	input  wire logic [3:0]           io_high,
	input  wire bhw_pkg::bhw_io_req_t io_req,
	output var  bhw_pkg::bhw_io_res_t io_res
);

	bhw_pkg::bhw_io_res_t state_reg;
	bhw_pkg::bhw_io_res_t state_next;
	logic [15:0]          low_addr;
	logic [15:0]          high_addr;

	// upper-half window registers are outside this slice, so bits 31:16 must be zero
	assign low_addr  = {io_low, `BHW_IO_LOW_FILL};
	assign high_addr = {io_high, `BHW_IO_HIGH_FILL};

	always_comb begin
		state_next       = state_reg;
		state_next.valid = io_req.valid;
		state_next.hit   = io_req.valid && (io_req.addr[31:16] == 16'h0000)
			&& (io_req.addr[15:0] >= low_addr)
			&& (io_req.addr[15:0] <= high_addr);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign io_res = state_reg;

endmodule : bhw_io_match

`default_nettype wire

/* File: bhw_regs.sv */
// bridge header slice: latency, header code, self test, base windows, bus numbers, io window
// How it works
// - both latency timer registers are read-only and read zero.
// - header layout code reads fixed 0x01 for single-function type 1.
// - self test register is read-only zero, no self test present.
// - both base window registers are read-only 32-bit zero.
// - upstream segment number is writable, resets zero, affects nothing.
// - downstream segment number is writable, resets zero.
// - highest segment number is writable, resets zero.
// - io window low bit 0 is lockable width flag, resets one.
// - io window high bit 0 mirrors the width flag, read-only.
// - io window low bits 7:4 writable, reset 0xf, give address 15:12.
// - io window high bits 7:4 writable, reset zero, low bits all ones.
// - io window values decide forwarding of io transactions.
`default_nettype none
`include "bhw_cfg.svh"

module bhw_regs (
	input  wire logic                  clk,
	input  wire logic                  arst_n,
	input  wire bhw_pkg::bhw_bus_req_t bus_req,
	output var  logic [31:0]           rd_data,
	input  wire bhw_pkg::bhw_io_req_t  io_req,
	output var  bhw_pkg::bhw_io_res_t  io_res,
	output var  logic                  wide_io_addressing
);

	bhw_pkg::bhw_regs_st_t state_reg;
	bhw_pkg::bhw_regs_st_t state_next;
	logic [5:0]            idx;
	logic [31:0]           mux_word;
	logic                  wr_upstream;
	logic                  wr_downstream;
	logic                  wr_highest;
	logic                  wr_io_low;
	logic                  wr_io_high;
	logic                  wr_lock;

	// address bits 1:0 are ignored, every register takes a whole word
	assign idx = bus_req.addr[7:2];

	assign wr_upstream   = bus_req.we && (idx == `BHW_IDX_UPSTREAM);
	assign wr_downstream = bus_req.we && (idx == `BHW_IDX_DOWNSTREAM);
	assign wr_highest    = bus_req.we && (idx == `BHW_IDX_HIGHEST);
	assign wr_io_low     = bus_req.we && (idx == `BHW_IDX_IO_LOW);
	assign wr_io_high    = bus_req.we && (idx == `BHW_IDX_IO_HIGH);
	assign wr_lock       = bus_req.we && (idx == `BHW_IDX_LOCK_CTRL);

	bhw_rd_mux u_rd_mux (
		.idx        (idx),
		.upstream   (state_reg.upstream),
		.downstream (state_reg.downstream),
		.highest    (state_reg.highest),
		.width_flag (state_reg.width_flag),
		.io_low     (state_reg.io_low),
		.io_high    (state_reg.io_high),
		.lock       (state_reg.lock),
		.word       (mux_word)
	);

	always_comb begin
		state_next = state_reg;
		// fixed registers have no storage, so a write there has nowhere to land
		if (wr_upstream) begin
			state_next.upstream = bus_req.wdata[7:0];
		end
		if (wr_downstream) begin
			state_next.downstream = bus_req.wdata[7:0];
		end
		if (wr_highest) begin
			state_next.highest = bus_req.wdata[7:0];
		end
		if (wr_io_low) begin
			state_next.io_low = bus_req.wdata[`BHW_POS_ADDR_MSB:`BHW_POS_ADDR_LSB];
			// flag frozen once the lock is set; reserved bits dropped
			if (!state_reg.lock) begin
				state_next.width_flag = bus_req.wdata[`BHW_POS_FLAG];
			end
		end
		if (wr_io_high) begin
			// bit 0 here is a mirror, the written value is discarded
			state_next.io_high = bus_req.wdata[`BHW_POS_ADDR_MSB:`BHW_POS_ADDR_LSB];
		end
		if (wr_lock) begin
			state_next.lock = bus_req.wdata[0];
		end
		// read data stands only in the cycle after the strobe
		state_next.rd_data = bus_req.re ? mux_word : 32'h0000_0000;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg.upstream   <= `BHW_RST_SEGMENT;
			state_reg.downstream <= `BHW_RST_SEGMENT;
			state_reg.highest    <= `BHW_RST_SEGMENT;
			state_reg.width_flag <= `BHW_RST_WIDTH_FLAG;
			state_reg.io_low     <= `BHW_RST_IO_LOW;
			state_reg.io_high    <= `BHW_RST_IO_HIGH;
			state_reg.lock       <= `BHW_RST_LOCK;
			state_reg.rd_data    <= 32'h0000_0000;
		end else begin
			state_reg <= state_next;
		end
	end

	assign rd_data            = state_reg.rd_data;
	assign wide_io_addressing = state_reg.width_flag;

	// window compare runs a cycle behind the request so the answer is a flop
	bhw_io_match u_io_match (
		.clk     (clk),
		.arst_n  (arst_n),
		.io_low  (state_reg.io_low),
		.io_high (state_reg.io_high),
		.io_req  (io_req),
		.io_res  (io_res)
	);

	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	logic [15:0] chk_low_addr;
	logic [15:0] chk_high_addr;
	assign chk_low_addr  = {state_reg.io_low, 12'h000};
	assign chk_high_addr = {state_reg.io_high, 12'hfff};

	logic [33:0] chk_fields;
	assign chk_fields = {state_reg.upstream, state_reg.downstream, state_reg.highest,
		state_reg.width_flag, state_reg.io_low, state_reg.io_high, state_reg.lock};

	latency_zero_a: assert property (
		bus_req.re && (idx == `BHW_IDX_PRI_LAT || idx == `BHW_IDX_SEC_LAT)
		|=> rd_data == 32'h0000_0000)
		else $error("latency timer read not zero");

	header_code_a: assert property (
		bus_req.re && idx == `BHW_IDX_HDR_CODE |=> rd_data == 32'h0000_0001)
		else $error("header layout code not 0x01");

	self_test_a: assert property (
		bus_req.re && idx == `BHW_IDX_SELF_TEST |=> rd_data == 32'h0000_0000)
		else $error("self test register not zero");

	base_window_a: assert property (
		bus_req.re && (idx == `BHW_IDX_BASE_ZERO || idx == `BHW_IDX_BASE_ONE)
		##1 bus_req.re && (idx == `BHW_IDX_BASE_ZERO || idx == `BHW_IDX_BASE_ONE)
		|=> rd_data == 32'h0000_0000)
		else $error("base window read not zero");

	base_direct_a: assert property (
		bus_req.re && (idx == `BHW_IDX_BASE_ZERO || idx == `BHW_IDX_BASE_ONE)
		|=> rd_data == 32'h0000_0000)
		else $error("base window register not zero");

	upstream_wr_a: assert property (
		wr_upstream ##1 (bus_req.re && idx == `BHW_IDX_UPSTREAM && !bus_req.we)
		|=> rd_data == {24'h00_0000, $past(bus_req.wdata[7:0], 2)})
		else $error("upstream number read back wrong");

	downstream_wr_a: assert property (
		wr_downstream |=> state_reg.downstream == $past(bus_req.wdata[7:0]))
		else $error("downstream number not stored");

	highest_wr_a: assert property (
		wr_highest |=> state_reg.highest == $past(bus_req.wdata[7:0])
		&& $stable(state_reg.upstream) && $stable(state_reg.downstream))
		else $error("highest number not stored or neighbour disturbed");

	flag_locked_a: assert property (
		wr_io_low && state_reg.lock |=> $stable(state_reg.width_flag))
		else $error("width flag changed while locked");

	flag_open_a: assert property (
		wr_io_low && !state_reg.lock
		|=> wide_io_addressing == $past(bus_req.wdata[0]))
		else $error("width flag write lost while unlocked");

	flag_mirror_a: assert property (
		bus_req.re && idx == `BHW_IDX_IO_HIGH |=> rd_data[0] == $past(state_reg.width_flag))
		else $error("io window high bit 0 does not mirror flag");

	mirror_ignore_a: assert property (
		wr_io_high && !wr_io_low |=> $stable(state_reg.width_flag))
		else $error("write to mirror bit changed width flag");

	low_field_a: assert property (
		wr_io_low ##1 (bus_req.re && idx == `BHW_IDX_IO_LOW && !bus_req.we)
		|=> rd_data[7:4] == $past(bus_req.wdata[7:4], 2))
		else $error("io window low field read back wrong");

	high_field_a: assert property (
		wr_io_high |=> state_reg.io_high == $past(bus_req.wdata[7:4]))
		else $error("io window high field not stored");

	reserved_zero_a: assert property (
		bus_req.re && (idx == `BHW_IDX_IO_LOW || idx == `BHW_IDX_IO_HIGH)
		|=> rd_data[3:1] == 3'h0 && rd_data[31:8] == 24'h00_0000)
		else $error("reserved bits not zero");

	fixed_after_write_a: assert property (
		bus_req.we && idx == `BHW_IDX_HDR_CODE ##1 (bus_req.re && idx == `BHW_IDX_HDR_CODE)
		|=> rd_data == 32'h0000_0001)
		else $error("write disturbed header layout code");

	rd_only_once_a: assert property (
		!bus_req.re |=> rd_data == 32'h0000_0000)
		else $error("read data outside its cycle");

	fwd_inside_a: assert property (
		io_req.valid && io_req.addr[31:16] == 16'h0000
		&& io_req.addr[15:0] >= chk_low_addr && io_req.addr[15:0] <= chk_high_addr
		|=> io_res.valid && io_res.hit)
		else $error("address inside window not forwarded");

	fwd_outside_a: assert property (
		io_req.valid && (io_req.addr[15:0] < chk_low_addr || io_req.addr[15:0] > chk_high_addr)
		|=> io_res.valid && !io_res.hit)
		else $error("address outside window forwarded");

	fwd_idle_a: assert property (
		!io_req.valid |=> !io_res.valid && !io_res.hit)
		else $error("forward answer without request");

	// per-register holds are stated per field so a stray write shows which field moved; the fixed-write and read checks compare chk_fields whole
	reset_values_a: assert property (
		$rose(arst_n) |-> state_reg.upstream == 8'h00 && state_reg.downstream == 8'h00
		&& state_reg.highest == 8'h00 && state_reg.width_flag == 1'b1
		&& state_reg.io_low == 4'hf && state_reg.io_high == 4'h0 && state_reg.lock == 1'b0)
		else $error("register not at reset value after release");

	fixed_write_ignored_a: assert property (
		bus_req.we && (idx == `BHW_IDX_PRI_LAT || idx == `BHW_IDX_HDR_CODE
		|| idx == `BHW_IDX_SELF_TEST || idx == `BHW_IDX_BASE_ZERO
		|| idx == `BHW_IDX_BASE_ONE || idx == `BHW_IDX_SEC_LAT || idx == 6'h11)
		|=> $stable(chk_fields))
		else $error("write to fixed register changed state");

	read_no_change_a: assert property (
		bus_req.re && !bus_req.we |=> $stable(chk_fields))
		else $error("read changed register state");

	unmapped_read_a: assert property (
		bus_req.re && idx == 6'h11 |=> rd_data == 32'h0000_0000)
		else $error("unmapped word read not zero");

	upper_zero_a: assert property (
		bus_req.re |=> rd_data[31:8] == 24'h00_0000)
		else $error("read data upper bits not zero");

	upstream_hold_a: assert property (
		!wr_upstream |=> $stable(state_reg.upstream))
		else $error("upstream number changed without write");

	upstream_isolated_a: assert property (
		wr_upstream |=> $stable(state_reg.width_flag) && $stable(state_reg.io_low)
		&& $stable(state_reg.io_high) && $stable(state_reg.lock))
		else $error("upstream write disturbed window state");

	downstream_hold_a: assert property (
		!wr_downstream |=> $stable(state_reg.downstream))
		else $error("downstream number changed without write");

	downstream_back_a: assert property (
		wr_downstream ##1 (bus_req.re && idx == `BHW_IDX_DOWNSTREAM && !bus_req.we)
		|=> rd_data == {24'h00_0000, $past(bus_req.wdata[7:0], 2)})
		else $error("downstream number read back wrong");

	highest_hold_a: assert property (
		!wr_highest |=> $stable(state_reg.highest))
		else $error("highest number changed without write");

	highest_back_a: assert property (
		wr_highest ##1 (bus_req.re && idx == `BHW_IDX_HIGHEST && !bus_req.we)
		|=> rd_data == {24'h00_0000, $past(bus_req.wdata[7:0], 2)})
		else $error("highest number read back wrong");

	flag_hold_a: assert property (
		!wr_io_low |=> $stable(state_reg.width_flag))
		else $error("width flag changed without write");

	flag_low_read_a: assert property (
		bus_req.re && idx == `BHW_IDX_IO_LOW |=> rd_data[0] == $past(state_reg.width_flag))
		else $error("io window low bit 0 not the flag");

	low_hold_a: assert property (
		!wr_io_low |=> $stable(state_reg.io_low))
		else $error("io window low field changed without write");

	low_stored_a: assert property (
		wr_io_low |=> state_reg.io_low == $past(bus_req.wdata[7:4]))
		else $error("io window low field not stored");

	high_hold_a: assert property (
		!wr_io_high |=> $stable(state_reg.io_high))
		else $error("io window high field changed without write");

	high_read_a: assert property (
		bus_req.re && idx == `BHW_IDX_IO_HIGH |=> rd_data[7:4] == $past(state_reg.io_high))
		else $error("io window high field read wrong");

	lock_hold_a: assert property (
		!wr_lock |=> $stable(state_reg.lock))
		else $error("lock changed without write");

	lock_stored_a: assert property (
		wr_lock |=> state_reg.lock == $past(bus_req.wdata[0]))
		else $error("lock write not stored");

	lock_isolated_a: assert property (
		wr_lock |=> $stable(state_reg.width_flag) && $stable(state_reg.io_low)
		&& $stable(state_reg.io_high))
		else $error("lock write disturbed window state");

	lock_read_a: assert property (
		bus_req.re && idx == `BHW_IDX_LOCK_CTRL |=> rd_data == {31'h0000_0000, $past(state_reg.lock)})
		else $error("lock read back wrong");

	fwd_valid_a: assert property (
		io_req.valid |=> io_res.valid)
		else $error("forward query without answer");

	fwd_hit_valid_a: assert property (
		io_res.hit |-> io_res.valid)
		else $error("forward hit without valid");

	fwd_upper_a: assert property (
		io_req.valid && io_req.addr[31:16] != 16'h0000 |=> !io_res.hit)
		else $error("address above 16 bits forwarded");

	fwd_empty_a: assert property (
		io_req.valid && state_reg.io_low > state_reg.io_high |=> !io_res.hit)
		else $error("empty window forwarded");

	fwd_low_edge_a: assert property (
		io_req.valid && io_req.addr == {16'h0000, chk_low_addr}
		&& state_reg.io_low <= state_reg.io_high |=> io_res.hit)
		else $error("window base address not forwarded");

	fwd_high_edge_a: assert property (
		io_req.valid && io_req.addr == {16'h0000, chk_high_addr}
		&& state_reg.io_low <= state_reg.io_high |=> io_res.hit)
		else $error("window limit address not forwarded");

	lock_write_c: cover property (wr_lock ##1 wr_io_low ##1 bus_req.re);
	flag_clear_c: cover property (wr_io_low && !state_reg.lock && !bus_req.wdata[0]);
	fwd_hit_c:    cover property (io_req.valid ##1 io_res.hit);
	fwd_miss_c:   cover property (io_req.valid ##1 !io_res.hit);
	bus_rdwr_c:   cover property (wr_highest ##1 bus_req.re && idx == `BHW_IDX_HIGHEST);

endmodule : bhw_regs

`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the bridge header register slice
`default_nettype none

`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fails++; \
	$display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end

module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	logic                  clk;
	logic                  arst_n;
	bhw_pkg::bhw_bus_req_t bus_req;
	logic [31:0]           rd_data;
	bhw_pkg::bhw_io_req_t  io_req;
	bhw_pkg::bhw_io_res_t  io_res;
	logic                  wide_io_addressing;
	logic [31:0]           rd_q[$];
	logic                  io_q[$];
	logic                  rd_seen = 1'b0;
	logic                  io_seen = 1'b0;
	logic [7:0]            seg[3];
	logic [3:0]            lo;
	logic [3:0]            hi;
	logic                  flag;
	logic                  lock;
	logic [31:0]           rnd;
	integer                seed;
	int                    fails;
	int                    comparisons;
	logic [31:0]           rd_exp;
	logic                  io_exp;
	logic [7:0]            ro_addr[7] = '{8'h34, 8'h38, 8'h3c, 8'h40, 8'h50, 8'h6c, 8'h44};
	logic [31:0]           edge_addr[6] =
		'{32'h0fff, 32'h1000, 32'h2fff, 32'h3000, 32'h1_1000, 32'h2000};

	bhw_regs bhw_regs_inst (
		.clk                (clk),
		.arst_n             (arst_n),
		.bus_req            (bus_req),
		.rd_data            (rd_data),
		.io_req             (io_req),
		.io_res             (io_res),
		.wide_io_addressing (wide_io_addressing)
	);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic conclude();
		$display("fails %0d comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : conclude

	task automatic model_reset();
		seg = '{8'h00, 8'h00, 8'h00};
		lo = 4'hf;
		hi = 4'h0;
		flag = 1'b1;
		lock = 1'b0;
	endtask : model_reset

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		bus_req.addr  <= a;
		bus_req.wdata <= d;
		bus_req.we    <= 1'b1;
		bus_req.re    <= 1'b0;
		io_req.valid  <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		bus_req.addr <= a;
		bus_req.we   <= 1'b0;
		bus_req.re   <= 1'b1;
		io_req.valid <= 1'b0;
		rd_q.push_back(e);
	endtask : rd

	task automatic idle();
		@(posedge clk);
		bus_req.we   <= 1'b0;
		bus_req.re   <= 1'b0;
		io_req.valid <= 1'b0;
	endtask : idle

	task automatic query(input logic [31:0] a);
		@(posedge clk);
		bus_req.we   <= 1'b0;
		bus_req.re   <= 1'b0;
		io_req.valid <= 1'b1;
		io_req.addr  <= a;
		io_q.push_back(a[31:16] == 16'h0 && a[15:0] >= {lo, 12'h000} && a[15:0] <= {hi, 12'hfff});
	endtask : query

	// every mapped word plus one unmapped hole, expected from the bench model
	task automatic check_map();
		rd(8'h34, 32'h0);
		rd(8'h6c, 32'h0);
		rd(8'h38, 32'h1);
		rd(8'h3c, 32'h0);
		rd(8'h40, 32'h0);
		rd(8'h50, 32'h0);
		rd(8'h60, {24'h0, seg[0]});
		rd(8'h64, {24'h0, seg[1]});
		rd(8'h68, {24'h0, seg[2]});
		rd(8'h70, {24'h0, lo, 3'h0, flag});
		rd(8'h74, {24'h0, hi, 3'h0, flag});
		rd(8'hc0, {31'h0, lock});
		rd(8'h44, 32'h0);
		idle();
	endtask : check_map

	// read data is due in the cycle after the strobe, io answer likewise
	always @(posedge clk) begin
		if (rd_seen === 1'b1) begin
			rd_exp = rd_q.pop_front();
			`CHK(rd_data, rd_exp)
		end
		if (io_seen === 1'b1) begin
			io_exp = io_q.pop_front();
			`CHK({io_res.valid, io_res.hit}, {1'b1, io_exp})
		end
		rd_seen <= bus_req.re;
		io_seen <= io_req.valid;
	end

	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		conclude();
	end

	initial begin
		seed = 32'h9c180a1e;
		arst_n = 1'b0;
		bus_req = '0;
		io_req = '0;
		fails = 0;
		comparisons = 0;
		model_reset();
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		check_map();
		`CHK(wide_io_addressing, 1'b1)
		query(32'h0000_f123);
		query(32'h0000_0000);
		// read-only words and reserved bits must shrug off all-ones writes
		foreach (ro_addr[i]) begin
			wr(ro_addr[i], 32'hffff_ffff);
		end
		wr(8'h38, 32'hffff_ffff);
		rd(8'h38, 32'h1);
		check_map();
		for (int i = 0; i < 9; i++) begin
			rnd = $random(seed);
			wr(8'h60 + 8'(4 * (i % 3)), rnd);
			seg[i % 3] = rnd[7:0];
			rd(8'h60 + 8'(4 * (i % 3)), {24'h0, rnd[7:0]});
		end
		wr(8'h70, 32'hffff_ff1e);
		wr(8'h74, 32'hffff_ff2f);
		lo = 4'h1;
		hi = 4'h2;
		flag = 1'b0;
		idle();
		`CHK(wide_io_addressing, 1'b0)
		check_map();
		// lock freezes the width flag but not the address field
		wr(8'hc0, 32'h1);
		wr(8'h70, 32'h31);
		lock = 1'b1;
		lo = 4'h3;
		idle();
		idle();
		`CHK(wide_io_addressing, 1'b0)
		check_map();
		wr(8'hc0, 32'h0);
		wr(8'h70, 32'h11);
		lock = 1'b0;
		lo = 4'h1;
		flag = 1'b1;
		check_map();
		foreach (edge_addr[i]) begin
			query(edge_addr[i]);
		end
		for (int i = 0; i < 16; i++) begin
			rnd = $random(seed);
			query({i[0] ? 16'h0 : rnd[31:16], 2'b00, rnd[13:0]});
		end
		wr(8'h70, 32'h50);
		lo = 4'h5;
		flag = 1'b0;
		rd(8'h70, {24'h0, 4'h5, 3'h0, 1'b0});
		wr(8'hc0, 32'h1);
		lock = 1'b1;
		query(32'h0000_5000);
		idle();
		idle();
		// second reset in mid-run restores every writable field
		arst_n <= 1'b0;
		repeat (3) @(posedge clk);
		`CHK(wide_io_addressing, 1'b1)
		arst_n <= 1'b1;
		model_reset();
		check_map();
		idle();
		idle();
		`CHK(rd_q.size(), 0)
		`CHK(io_q.size(), 0)
		conclude();
	end
endmodule : testbench

`default_nettype wire
